// ==== design/isr_slave.sv ====
// Two-wire slave port with register pointer and circular-buffer readout.
// Bus logic runs on LINK_CLK oversampling the pins; register and buffer
// strobes run on SYS_CLK; a toggle handshake carries each access across.
`default_nettype none

module isr_slave
    import isr_pkg::*;
#(
    parameter int BUF_LEN = BUF_LEN_DEF
) (
    input  wire logic       LINK_CLK,       // Bus oversampling clock
    input  wire logic       SYS_CLK,        // System clock
    input  wire logic       RST_N,          // Async reset, active low
    input  wire logic       CE,             // Clock enable, system side
    isr_if.dev              BUS,            // Bus pins
    input  wire logic [1:0] ADDR_SEL_LOW,   // Low address strap level
    input  wire logic [1:0] ADDR_SEL_HIGH,  // High address strap level
    input  wire logic       REBOOT_BUSY,    // Software reboot in progress
    input  wire logic       TEN_BIT_MODE,   // Buffer readout width select
    output logic            REG_RD,         // Register read strobe
    output logic            REG_WR,         // Register write strobe
    output logic            NV_ADDR_WR,     // Nonvolatile address low-byte strobe
    output logic            BUF_RD,         // Sample buffer read strobe
    output logic [7:0]      REG_ADDR,       // Register or command address
    output logic [7:0]      REG_WDATA,      // Write data
    output logic [1:0]      BUF_SEL,        // Sample buffer number
    output logic [5:0]      BUF_IDX,        // Sample age, zero is oldest
    input  wire logic [7:0] REG_RDATA,      // Register read data
    input  wire logic [9:0] BUF_RDATA       // Sample read data
);

    if (BUF_LEN < 2 || BUF_LEN > 64) begin : g_chk
        $error("BUF_LEN out of range");
    end

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX   = 3'b001,
        D_ACK  = 3'b010,
        D_TX   = 3'b011,
        D_MACK = 3'b100
    } isr_dst_t;

    typedef enum logic [1:0] {
        OP_RD  = 2'b00,
        OP_WR  = 2'b01,
        OP_NV  = 2'b10,
        OP_BUF = 2'b11
    } isr_op_t;

    // Link-side state
    typedef struct packed {
        logic       scl1, scl2, scl3, sda1, sda2, sda3;
        logic       bsy1, bsy2, ten1, ten2, ak1, ak2, ak3;
        logic [3:0] sel1, sel2;
        isr_dst_t   st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic       rw, adr_ph, first, acked, sda_oe;
        logic [7:0] ptr;
        logic       bufm, ten, half;
        logic [1:0] low2;
        logic [5:0] cnt;
        logic [9:0] word;
        logic       req;
        isr_op_t    op;
        logic [7:0] addr, wd;
        logic [5:0] idx;
    } isr_lnk_t;

    // System-side state
    typedef struct packed {
        logic       rq1, rq2, rq3, ack, ph;
        logic       rd, wr, nv, br;
        logic [7:0] addr, wd;
        logic [1:0] sel;
        logic [5:0] idx;
        logic [9:0] rdata;
    } isr_sys_t;

    isr_lnk_t l_r;
    isr_lnk_t l_nxt;
    isr_sys_t s_r;
    isr_sys_t s_nxt;
    logic     rise, fall, start, stop;

    // Fetch the next byte to send; pointer steps only outside readout
    function automatic isr_lnk_t fetch(input isr_lnk_t l);
        if (l.bufm) begin
            if (!(l.ten && l.half)) begin
                l.req = ~l.req;
                l.op = OP_BUF;
                l.addr = l.ptr;
                l.idx = (l.cnt == 6'(BUF_LEN - 1)) ? 6'h00 : l.cnt + 6'h01;
                l.cnt = (l.cnt == 6'(BUF_LEN - 1)) ? 6'h00 : l.cnt + 6'h01;
            end
        end else begin
            l.req = ~l.req;
            l.op = OP_RD;
            l.addr = l.ptr;
            l.ptr = isr_ptr_inc(l.ptr);
        end
        return l;
    endfunction

    // Load the fetched byte into the shifter and drive its first bit
    function automatic isr_lnk_t load(input isr_lnk_t l);
        if (l.bufm && l.ten && l.half) begin
            l.sh = {6'h00, l.low2};
            l.half = 1'b0;
        end else if (l.bufm) begin
            l.sh = l.word[9:2];
            l.low2 = l.word[1:0];
            l.half = l.ten;
        end else begin
            l.sh = l.word[7:0];
        end
        l.sda_oe = ~l.sh[7];
        l.bits = 4'h0;
        l.st = D_TX;
        return l;
    endfunction

    // Bus events from synchronised pins
    assign rise = l_r.scl2 & ~l_r.scl3;
    assign fall = ~l_r.scl2 & l_r.scl3;
    assign start = l_r.scl2 & l_r.scl3 & l_r.sda3 & ~l_r.sda2;
    assign stop = l_r.scl2 & l_r.scl3 & ~l_r.sda3 & l_r.sda2;

    // Link-side protocol engine
    always_comb begin
        l_nxt = l_r;
        l_nxt.scl1 = BUS.scl;
        l_nxt.scl2 = l_r.scl1;
        l_nxt.scl3 = l_r.scl2;
        l_nxt.sda1 = BUS.sda;
        l_nxt.sda2 = l_r.sda1;
        l_nxt.sda3 = l_r.sda2;
        l_nxt.bsy1 = REBOOT_BUSY;
        l_nxt.bsy2 = l_r.bsy1;
        l_nxt.ten1 = TEN_BIT_MODE;
        l_nxt.ten2 = l_r.ten1;
        l_nxt.sel1 = {ADDR_SEL_HIGH, ADDR_SEL_LOW};
        l_nxt.sel2 = l_r.sel1;
        l_nxt.ak1 = s_r.ack;
        l_nxt.ak2 = l_r.ak1;
        l_nxt.ak3 = l_r.ak2;
        if (l_r.ak2 != l_r.ak3) begin
            l_nxt.word = s_r.rdata;
        end
        if (stop) begin
            l_nxt.st = D_IDLE;
            l_nxt.sda_oe = 1'b0;
        end else if (start) begin
            l_nxt.st = D_RX;
            l_nxt.bits = 4'h0;
            l_nxt.adr_ph = 1'b1;
            l_nxt.sda_oe = 1'b0;
        end else begin
            unique case (l_r.st)
                D_IDLE: ;
                D_RX: begin
                    if (rise) begin
                        l_nxt.sh = {l_r.sh[6:0], l_r.sda2};
                        l_nxt.bits = l_r.bits + 4'h1;
                    end else if (fall && l_r.bits == 4'h8) begin
                        l_nxt.st = D_ACK;
                        if (l_r.adr_ph) begin
                            // Address byte
                            l_nxt.acked = (l_r.sh[7:1] == isr_slave_addr(l_r.sel2[3:2], l_r.sel2[1:0]))
                                          && !l_r.bsy2;
                            l_nxt.rw = l_r.sh[0];
                            l_nxt.adr_ph = 1'b0;
                            l_nxt.first = 1'b1;
                            if (l_nxt.acked && l_r.sh[0]) begin
                                l_nxt = fetch(l_nxt);
                            end
                        end else if (l_r.first) begin
                            // Pointer or command byte
                            l_nxt.first = 1'b0;
                            l_nxt.acked = isr_ptr_ok(l_r.sh);
                            if (l_nxt.acked) begin
                                l_nxt.ptr = l_r.sh;
                                l_nxt.bufm = (l_r.sh >= PTR_BUF_MIN && l_r.sh <= PTR_BUF_MAX);
                                l_nxt.cnt = 6'h00;
                                l_nxt.half = 1'b0;
                                l_nxt.ten = l_r.ten2;
                            end
                        end else if (l_r.ptr >= CMD_NV_MIN && l_r.ptr <= CMD_NV_MAX) begin
                            l_nxt.acked = 1'b1;
                            l_nxt.req = ~l_r.req;
                            l_nxt.op = OP_NV;
                            l_nxt.addr = l_r.ptr;
                            l_nxt.wd = l_r.sh;
                        end else if (l_r.ptr <= PTR_CFG_MAX && !l_r.bufm) begin
                            l_nxt.acked = 1'b1;
                            l_nxt.req = ~l_r.req;
                            l_nxt.op = OP_WR;
                            l_nxt.addr = l_r.ptr;
                            l_nxt.wd = l_r.sh;
                            l_nxt.ptr = isr_ptr_inc(l_r.ptr);
                        end else begin
                            l_nxt.acked = 1'b0;
                        end
                        l_nxt.sda_oe = l_nxt.acked;
                    end
                end
                D_ACK: begin
                    if (fall) begin
                        l_nxt.sda_oe = 1'b0;
                        l_nxt.bits = 4'h0;
                        if (!l_r.acked) begin
                            l_nxt.st = D_IDLE;
                        end else if (l_r.rw) begin
                            l_nxt = load(l_nxt);
                        end else begin
                            l_nxt.st = D_RX;
                        end
                    end
                end
                D_TX: begin
                    if (fall) begin
                        l_nxt.bits = l_r.bits + 4'h1;
                        if (l_r.bits == 4'h7) begin
                            l_nxt.sda_oe = 1'b0;
                            l_nxt.st = D_MACK;
                        end else begin
                            l_nxt.sh = {l_r.sh[6:0], 1'b0};
                            l_nxt.sda_oe = ~l_r.sh[6];
                        end
                    end
                end
                D_MACK: begin
                    if (rise) begin
                        l_nxt.acked = ~l_r.sda2;
                        if (l_r.sda2) begin
                            l_nxt.bufm = 1'b0;
                            l_nxt.st = D_IDLE;
                        end else begin
                            l_nxt = fetch(l_nxt);
                        end
                    end else if (fall) begin
                        l_nxt = load(l_nxt);
                    end
                end
                default: l_nxt.st = D_IDLE;
            endcase
        end
    end

    // Link-side register
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // System side: strobe one cycle per request, capture read data, toggle back
    always_comb begin
        s_nxt = s_r;
        s_nxt.rq1 = l_r.req;
        s_nxt.rq2 = s_r.rq1;
        s_nxt.rq3 = s_r.rq2;
        s_nxt.rd = 1'b0;
        s_nxt.wr = 1'b0;
        s_nxt.nv = 1'b0;
        s_nxt.br = 1'b0;
        if (s_r.ph) begin
            s_nxt.ph = 1'b0;
            s_nxt.rdata = s_r.br ? BUF_RDATA : {2'h0, REG_RDATA};
            s_nxt.ack = ~s_r.ack;
        end else if (s_r.rq2 != s_r.rq3) begin
            s_nxt.ph = 1'b1;
            s_nxt.rd = (l_r.op == OP_RD);
            s_nxt.wr = (l_r.op == OP_WR);
            s_nxt.nv = (l_r.op == OP_NV);
            s_nxt.br = (l_r.op == OP_BUF);
            s_nxt.addr = l_r.addr;
            s_nxt.wd = l_r.wd;
            s_nxt.sel = l_r.addr[1:0] - PTR_BUF_MIN[1:0];
            s_nxt.idx = l_r.idx;
        end
    end

    // System-side register
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_r <= '0;
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign REG_RD = s_r.rd;
    assign REG_WR = s_r.wr;
    assign NV_ADDR_WR = s_r.nv;
    assign BUF_RD = s_r.br;
    assign REG_ADDR = s_r.addr;
    assign REG_WDATA = s_r.wd;
    assign BUF_SEL = s_r.sel;
    assign BUF_IDX = s_r.idx;
    assign BUS.sda_s_o = 1'b0;
    assign BUS.sda_s_oe = l_r.sda_oe;

endmodule

`default_nettype wire

// ==== design/isr_pkg.sv ====
// Shared constants and helpers for the two-wire slave port and its master.
// Assumes both ends run from a 40 MHz system clock.
`default_nettype none

package isr_pkg;

    // Pointer ranges
    localparam logic [7:0] PTR_CFG_MAX = 8'h45;
    localparam logic [7:0] PTR_BUF_MIN = 8'h46;
    localparam logic [7:0] PTR_BUF_MAX = 8'h49;
    localparam logic [7:0] CMD_NV_MIN  = 8'h80;
    localparam logic [7:0] CMD_NV_MAX  = 8'h82;
    localparam logic [7:0] PTR_RST     = 8'h00;

    // Samples per circular buffer
    localparam int         BUF_LEN_DEF = 50;

    // Three-level strap codes
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;

    // Slave address parts chosen by the high and low select straps
    localparam logic [6:0] SADR_HI_LOW  = 7'h38;
    localparam logic [6:0] SADR_HI_HIGH = 7'h34;
    localparam logic [6:0] SADR_HI_OPEN = 7'h30;
    localparam logic [6:0] SADR_LO_LOW  = 7'h02;
    localparam logic [6:0] SADR_LO_HIGH = 7'h01;
    localparam logic [6:0] SADR_LO_OPEN = 7'h00;

    // Bus timing: 100 kHz bit rate split in four quarters
    localparam int SYS_CLK_NS  = 25;
    localparam int SCL_BIT_NS  = 10000;
    localparam int SCL_QTR_CYC = SCL_BIT_NS / (4 * SYS_CLK_NS);

    // Seven-bit slave address from the two straps
    function automatic logic [6:0] isr_slave_addr(input logic [1:0] hi, input logic [1:0] lo);
        logic [6:0] a;
        logic [6:0] b;
        a = (hi == LVL_LOW) ? SADR_HI_LOW : (hi == LVL_HIGH) ? SADR_HI_HIGH : SADR_HI_OPEN;
        b = (lo == LVL_LOW) ? SADR_LO_LOW : (lo == LVL_HIGH) ? SADR_LO_HIGH : SADR_LO_OPEN;
        return a | b;
    endfunction

    // Pointer step with wrap after the last register
    function automatic logic [7:0] isr_ptr_inc(input logic [7:0] p);
        return (p >= PTR_BUF_MAX) ? PTR_RST : p + 8'h01;
    endfunction

    // Values a pointer load may take
    function automatic logic isr_ptr_ok(input logic [7:0] p);
        return (p <= PTR_BUF_MAX) || (p >= CMD_NV_MIN && p <= CMD_NV_MAX);
    endfunction

endpackage

`default_nettype wire

// ==== design/isr_if.sv ====
// Two-wire bus carrier joining the slave port and the master.
// Both lines are open drain; levels are resolved here from the enables.
`default_nettype none

interface isr_if;
    logic scl_o;     // Master clock drive value
    logic scl_oe;    // Master pulls clock low
    logic sda_m_o;   // Master data drive value
    logic sda_m_oe;  // Master pulls data low
    logic sda_s_o;   // Slave data drive value
    logic sda_s_oe;  // Slave pulls data low
    logic scl;       // Resolved clock line
    logic sda;       // Resolved data line

    // Wired-AND with pull-ups
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_s_oe & ~sda_s_o);

    modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport mst (input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

`default_nettype wire

// ==== design/isr_master.sv ====
// Two-wire bus master: one byte per command, optional START before and STOP after.
// Makes the bus clock from SYS_CLK by a quarter-bit divider; no clock stretching.
`default_nettype none

module isr_master
    import isr_pkg::*;
#(
    parameter int QTR_CYC = SCL_QTR_CYC
) (
    input  wire logic       SYS_CLK,    // System clock
    input  wire logic       RST_N,      // Async reset, active low
    input  wire logic       CE,         // Clock enable
    isr_if.mst              BUS,        // Bus pins
    input  wire logic       CMD_VALID,  // Command offered
    output logic            CMD_READY,  // Command taken
    input  wire logic       CMD_START,  // START or repeated START first
    input  wire logic       CMD_STOP,   // STOP after the byte
    input  wire logic       CMD_READ,   // Read a byte instead of writing
    input  wire logic       CMD_NACK,   // Answer a read byte with no acknowledge
    input  wire logic [7:0] CMD_DATA,   // Byte to write
    output logic            RSP_VALID,  // Byte finished
    output logic [7:0]      RSP_DATA,   // Byte read
    output logic            RSP_ACK     // Slave acknowledged the written byte
);

    if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_chk
        $error("QTR_CYC out of range");
    end

    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_START = 2'b01,
        M_BIT   = 2'b10,
        M_STOP  = 2'b11
    } isr_mst_t;

    typedef struct packed {
        isr_mst_t    st;
        logic [1:0]  q;
        logic [15:0] div;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        rd;
        logic        nack;
        logic        stp;
        logic        scl_oe;
        logic        sda_oe;
        logic        sd1;
        logic        sd2;
        logic [7:0]  rdat;
        logic        rack;
        logic        rvld;
    } isr_mreg_t;

    isr_mreg_t m_r;
    isr_mreg_t m_nxt;
    logic      tick;

    // Quarter-bit tick
    assign tick = (m_r.div == 16'(QTR_CYC - 1));

    // Sequencer
    always_comb begin
        m_nxt = m_r;
        m_nxt.sd1 = BUS.sda;
        m_nxt.sd2 = m_r.sd1;
        m_nxt.rvld = 1'b0;
        m_nxt.div = tick ? 16'h0000 : m_r.div + 16'h0001;
        if (tick && m_r.st != M_IDLE) begin
            m_nxt.q = m_r.q + 2'h1;
        end
        unique case (m_r.st)
            M_IDLE: begin
                if (CMD_VALID) begin
                    m_nxt.sh = CMD_DATA;
                    m_nxt.rd = CMD_READ;
                    m_nxt.nack = CMD_NACK;
                    m_nxt.stp = CMD_STOP;
                    m_nxt.bitn = 4'h0;
                    m_nxt.q = 2'h0;
                    m_nxt.div = 16'h0000;
                    m_nxt.st = CMD_START ? M_START : M_BIT;
                end
            end
            M_START: begin
                if (tick) begin
                    unique case (m_r.q)
                        2'h0: m_nxt.sda_oe = 1'b0;
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b1;
                        2'h3: begin
                            m_nxt.scl_oe = 1'b1;
                            m_nxt.st = M_BIT;
                        end
                    endcase
                end
            end
            M_BIT: begin
                if (tick) begin
                    unique case (m_r.q)
                        // Data moves only while the clock is low
                        2'h0: m_nxt.sda_oe = (m_r.bitn < 4'h8) ? (~m_r.rd & ~m_r.sh[7])
                                                               : (m_r.rd & ~m_r.nack);
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (m_r.bitn < 4'h8) begin
                                m_nxt.sh = {m_r.sh[6:0], m_r.sd2};
                            end else begin
                                m_nxt.rack = ~m_r.sd2;
                            end
                        end
                        2'h3: begin
                            m_nxt.scl_oe = 1'b1;
                            m_nxt.bitn = m_r.bitn + 4'h1;
                            if (m_r.bitn == 4'h8) begin
                                m_nxt.rvld = 1'b1;
                                m_nxt.rdat = m_r.sh;
                                m_nxt.st = m_r.stp ? M_STOP : M_IDLE;
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (tick) begin
                    unique case (m_r.q)
                        2'h0: m_nxt.sda_oe = 1'b1;
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b0;
                        2'h3: m_nxt.st = M_IDLE;
                    endcase
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            m_r <= '0;
        end else if (CE) begin
            m_r <= m_nxt;
        end
    end

    // Outputs
    assign CMD_READY = (m_r.st == M_IDLE);
    assign RSP_VALID = m_r.rvld;
    assign RSP_DATA = m_r.rdat;
    assign RSP_ACK = m_r.rack;
    assign BUS.scl_o = 1'b0;
    assign BUS.scl_oe = m_r.scl_oe;
    assign BUS.sda_m_o = 1'b0;
    assign BUS.sda_m_oe = m_r.sda_oe;

endmodule

`default_nettype wire

// ==== verif/isr_chk.sv ====
// Checks on the two-wire bus between slave port and master.
// Sees the resolved lines and the slave drive, on the link clock.
`default_nettype none
module isr_chk (
    input wire logic LINK_CLK, // Link clock
    input wire logic RST_N,    // Reset, active low
    input wire logic scl,      // Clock line
    input wire logic sda,      // Data line
    input wire logic sda_s_o,  // Slave drive value
    input wire logic sda_s_oe  // Slave drive enable
);
    logic scl_r, sda_r, pull, start, stop;
    // Line levels one link cycle back
    always_ff @(posedge LINK_CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_r <= 1'h1;
            sda_r <= 1'h1;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
        end
    end
    // Slave pull and bus conditions
    assign pull  = sda_s_oe & ~sda_s_o;
    assign start = scl & scl_r & sda_r & ~sda;
    assign stop  = scl & scl_r & ~sda_r & sda;
    default clocking @(posedge LINK_CLK); endclocking
    default disable iff (!RST_N);
    property p_hold; scl && scl_r |-> $stable(pull); endproperty
    a_hold: assert property (p_hold) else $error("slave moved data");
    property p_start; start |-> !pull [*8]; endproperty
    a_start: assert property (p_start) else $error("pull at start");
    property p_free; stop |-> (scl && sda) [*8]; endproperty
    a_free: assert property (p_free) else $error("bus busy after stop");
    property p_stop; stop |-> !pull [*8]; endproperty
    a_stop: assert property (p_stop) else $error("pull after stop");
    property p_sep; start |=> !stop until !scl; endproperty
    a_sep: assert property (p_sep) else $error("stop in start pulse");
    property p_clk; start |-> ##[1:100] !scl; endproperty
    a_clk: assert property (p_clk) else $error("no clock after start");
    property p_ack; $rose(pull) |-> !scl; endproperty
    a_ack: assert property (p_ack) else $error("pull with clock high");
    property p_rel; $rose(pull) |-> ##[1:1000] !pull; endproperty
    a_rel: assert property (p_rel) else $error("data never released");
    // Main bus events
    c_start: cover property (start);
    c_stop: cover property (stop);
    c_pull: cover property ($rose(pull));
endmodule
`default_nettype wire

// ==== verif/i2c_slave_reg_and_ring_readout_test.sv ====
// Master and slave port on one bus; register bank and buffers live here.
// Expected bytes come from a model of the pointer rules.
`default_nettype none
module i2c_slave_reg_and_ring_readout_test import isr_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int L = 6;              // Short buffers keep the run brief
    localparam logic [6:0] SA = 7'h39; // Address for the strap levels used
    logic sys_clk = 0, link_clk = 0, rst_n = 0, reboot = 0, ten = 0;
    logic cv = 0, cs = 0, cp = 0, cr = 0, cn = 0, rdy, rv, ra, rwr, nvw, rrd, brd;
    logic [7:0] cd = 0, rq, ad, wd, e, em [256], mem [256];
    logic [1:0] bs;
    logic [5:0] bi;
    logic [9:0] q, samp [4][64];
    logic [15:0] nvl;
    logic [31:0] seed = 32'h81995626;
    int mismatches = 0, n_checks = 0, n_rd = 0, n_br = 0;
    isr_if bus ();
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    isr_master #(.QTR_CYC(16)) u_isr_master (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(1'h1), .BUS(bus),
        .CMD_VALID(cv), .CMD_READY(rdy), .CMD_START(cs), .CMD_STOP(cp), .CMD_READ(cr), .CMD_NACK(cn),
        .CMD_DATA(cd), .RSP_VALID(rv), .RSP_DATA(rq), .RSP_ACK(ra));
    isr_slave #(.BUF_LEN(L)) u_isr_slave (.LINK_CLK(link_clk), .SYS_CLK(sys_clk), .RST_N(rst_n),
        .CE(1'h1), .BUS(bus), .ADDR_SEL_LOW(LVL_HIGH), .ADDR_SEL_HIGH(LVL_LOW), .REBOOT_BUSY(reboot),
        .TEN_BIT_MODE(ten), .REG_RD(rrd), .REG_WR(rwr), .NV_ADDR_WR(nvw), .BUF_RD(brd), .REG_ADDR(ad),
        .REG_WDATA(wd), .BUF_SEL(bs), .BUF_IDX(bi), .REG_RDATA(mem[ad]), .BUF_RDATA(samp[bs][bi]));
    isr_chk u_isr_chk (.LINK_CLK(link_clk), .RST_N(rst_n), .scl(bus.scl), .sda(bus.sda),
        .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe));
    // Register bank and nonvolatile address latch behind the strobes
    always @(posedge sys_clk) begin
        if (rwr) mem[ad] <= wd;
        if (nvw) nvl <= {ad, wd};
        if (rrd) n_rd++;
        if (brd) n_br++;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
        n_checks++;
        if (s !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    // One byte through the master, held until taken, then wait for its end
    task automatic xb(input logic s, input logic p, input logic r, input logic k, input logic [7:0] d);
        @(posedge sys_clk);
        {cv, cs, cp, cr, cn, cd} <= {1'h1, s, p, r, k, d};
        do @(negedge sys_clk); while (!rdy);
        @(posedge sys_clk);
        cv <= 1'h0;
        for (int i = 0; i < 9999 && !rv; i++) @(negedge sys_clk);
        if (!rv) begin
            mismatches++;
            $display("CHECK FAILED byte done expected 1 seen 0");
        end
    endtask
    task automatic wr(input logic s, input logic p, input logic [7:0] d, input logic k);
        xb(s, p, 1'h0, 1'h0, d);
        chk("ack", {7'h00, k}, {7'h00, ra});
    endtask
    task automatic sb(input logic [7:0] v, input logic k);
        wr(1'h1, 1'h0, {SA, 1'h0}, 1'h1);
        wr(1'h0, 1'h1, v, k);
    endtask
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
            em[i] = 8'h00;
        end
        foreach (samp[b, i]) begin
            seed = xs(seed);
            samp[b][i] = seed[9:0];
        end
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'h1;
        wr(1'h1, 1'h1, {SA ^ 7'h04, 1'h0}, 1'h0);
        @(posedge sys_clk);
        reboot <= 1'h1;
        wr(1'h1, 1'h1, {SA, 1'h0}, 1'h0);
        @(posedge sys_clk);
        reboot <= 1'h0;
        sb(8'h4A, 1'h0);
        sb(8'h83, 1'h0);
        wr(1'h1, 1'h0, {SA, 1'h0}, 1'h1);
        wr(1'h0, 1'h0, 8'h44, 1'h1);
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            if (i < 2) em[8'h44 + i] = seed[7:0];
            wr(1'h0, 1'h0, seed[7:0], i < 2);
        end
        wr(1'h1, 1'h0, {SA, 1'h0}, 1'h1);
        wr(1'h0, 1'h0, 8'h81, 1'h1);
        wr(1'h0, 1'h1, seed[15:8], 1'h1);
        chk("nv", seed[15:8], nvl[7:0]);
        sb(8'h43, 1'h1);
        wr(1'h1, 1'h1, {SA, 1'h0}, 1'h1);
        wr(1'h1, 1'h0, {SA, 1'h1}, 1'h1);
        for (int i = 0; i < 3; i++) begin
            xb(1'h0, i == 2, 1'h1, i == 2, 8'h00);
            chk("reg", em[8'h43 + i], rq);
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            ten <= m[0];
            sb(8'h46 + m, 1'h1);
            wr(1'h1, 1'h0, {SA, 1'h1}, 1'h1);
            for (int j = 0; j < L * (m + 1); j++) begin
                q = samp[m][(j / (m + 1) + 1) % L];
                e = (m && j % 2) ? {6'h00, q[1:0]} : q[9:2];
                xb(1'h0, j == L * (m + 1) - 1, 1'h1, j == L * (m + 1) - 1, 8'h00);
                chk("sample", e, rq);
            end
        end
        // One register strobe per byte fetched, one buffer strobe per sample
        chk("reg reads", 8'h03, 8'(n_rd));
        chk("buffer reads", 8'(2 * L), 8'(n_br));
        stop_test();
    end
    // Cuts a hung run short
    initial begin
        #2ms;
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
